// ---- rtl/pdio_top.sv ----
// digital i/o ports: three bidir byte groups, dedicated in/out words, level irq
// Functional notes
// - all i/o except irq status disabled at power-up until enabled
// - enable low blocks bidir operations
// - bidir groups come up as inputs
// - bidir output latches may start undefined
// - three byte groups, independent direction each
// - input group reads its pin levels
// - output group reads its latch
// - input write updates latch; output drives instantly
// - dedicated input reads pins only when enabled
// - dedicated output drives only when enabled
// - dedicated output latch clears at power-up
// - four irq sources from group two
// - level irq, high while enabled source active
// - per-source polarity inverter before detection
`timescale 1ns/100ps
module pdio_top
	import pdio_pkg::*;
(
	// clock, reset, clock enable
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic clk_en_i,
	// control from host side
	input wire logic io_enable_i,
	input wire logic [PDIO_NUM_GRP-1:0] grp_dir_out_i,
	input wire logic [PDIO_NUM_GRP-1:0] grp_wr_i,
	input wire logic [PDIO_GRP_W-1:0] grp_wdata_i,
	input wire logic dout_wr_i,
	input wire logic [PDIO_DED_W-1:0] dout_wdata_i,
	input wire logic [PDIO_IRQ_N-1:0] irq_mask_i,
	input wire logic [PDIO_IRQ_N-1:0] irq_invert_i,
	// readback to host side
	output logic [PDIO_BIDIR_W-1:0] grp_rdata_o,
	output logic [PDIO_DED_W-1:0] din_rdata_o,
	output logic [PDIO_IRQ_N-1:0] irq_status_o,
	output logic irq_o,
	// bidir connector pins
	input wire logic [PDIO_BIDIR_W-1:0] bidir_pin_i,
	output logic [PDIO_BIDIR_W-1:0] bidir_pin_o,
	output logic [PDIO_BIDIR_W-1:0] bidir_pin_oe_n_o,
	// dedicated headers
	input wire logic [PDIO_DED_W-1:0] in_line_i,
	output logic [PDIO_DED_W-1:0] out_line_o,
	output logic out_line_oe_n_o
);
	// ------------------------------------------------------------
	// control state
	// ------------------------------------------------------------
	pdio_mode_t mode_q;
	logic [PDIO_NUM_GRP-1:0] dir_q;
	logic [PDIO_BIDIR_W-1:0] latch_q;
	logic [PDIO_DED_W-1:0] dout_q;
	logic [PDIO_IRQ_N-1:0] mask_q;
	logic [PDIO_IRQ_N-1:0] pol_q;
	logic en_w;
	logic [PDIO_IRQ_N-1:0] src_w;
	logic [PDIO_IRQ_N-1:0] act_w;
	logic irq_d;

	// enable decode
	assign en_w = (mode_q == PDIO_ON);

	// mode follows the global enable line; reset forces off
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			mode_q <= PDIO_OFF;
		end else if (clk_en_i) begin
			mode_q <= io_enable_i ? PDIO_ON : PDIO_OFF;
		end
	end

	// ------------------------------------------------------------
	// bidirectional groups
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < PDIO_NUM_GRP; g++) begin : g_grp
			logic [PDIO_GRP_W-1:0] rd_w;
			logic drive_w;
			// read mux: pins when input, latch when output
			assign rd_w = dir_q[g] ? latch_q[g*PDIO_GRP_W +: PDIO_GRP_W]
				: bidir_pin_i[g*PDIO_GRP_W +: PDIO_GRP_W];
			assign drive_w = en_w && dir_q[g];

			// direction, reset to input
			always_ff @(posedge sys_clk_i) begin
				if (srst_i) begin
					dir_q[g] <= PDIO_DIR_RST[g];
				end else if (clk_en_i && en_w) begin
					dir_q[g] <= grp_dir_out_i[g];
				end
			end

			// latch: no reset, written in either direction
			// contents stay unknown until the host writes them
			always_ff @(posedge sys_clk_i) begin
				if (clk_en_i && en_w && grp_wr_i[g]) begin
					latch_q[g*PDIO_GRP_W +: PDIO_GRP_W] <= grp_wdata_i;
				end
			end

			// registered readback and pin drive
			// oe takes the direction input itself, so a switch to output drives at once
			always_ff @(posedge sys_clk_i) begin
				if (srst_i) begin
					grp_rdata_o[g*PDIO_GRP_W +: PDIO_GRP_W] <= PDIO_BYTE_ZERO;
					bidir_pin_o[g*PDIO_GRP_W +: PDIO_GRP_W] <= PDIO_BYTE_ZERO;
					bidir_pin_oe_n_o[g*PDIO_GRP_W +: PDIO_GRP_W] <= ~PDIO_BYTE_ZERO;
				end else if (clk_en_i) begin
					grp_rdata_o[g*PDIO_GRP_W +: PDIO_GRP_W] <= en_w ? rd_w
						: PDIO_BYTE_ZERO;
					bidir_pin_o[g*PDIO_GRP_W +: PDIO_GRP_W] <=
						(drive_w && grp_wr_i[g]) ? grp_wdata_i
						: latch_q[g*PDIO_GRP_W +: PDIO_GRP_W];
					bidir_pin_oe_n_o[g*PDIO_GRP_W +: PDIO_GRP_W] <=
						{PDIO_GRP_W{~(en_w && grp_dir_out_i[g])}};
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// dedicated input and output words
	// ------------------------------------------------------------
	// oe follows the enable line itself, one cycle behind it
	// output latch clears at reset; input gated by enable
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			dout_q <= PDIO_DOUT_RST;
			din_rdata_o <= PDIO_WORD_ZERO;
			out_line_o <= PDIO_WORD_ZERO;
			out_line_oe_n_o <= 1'b1;
		end else if (clk_en_i) begin
			if (en_w && dout_wr_i) begin
				dout_q <= dout_wdata_i;
			end
			din_rdata_o <= en_w ? in_line_i : PDIO_WORD_ZERO;
			out_line_o <= (en_w && dout_wr_i) ? dout_wdata_i : dout_q;
			out_line_oe_n_o <= ~io_enable_i;
		end
	end

	// ------------------------------------------------------------
	// interrupt sources
	// ------------------------------------------------------------
	// raw levels of group two low nibble, polarity, mask
	assign src_w = bidir_pin_i[PDIO_IRQ_GRP*PDIO_GRP_W +: PDIO_IRQ_N];
	assign act_w = (src_w ^ pol_q) & mask_q;
	assign irq_d = en_w && (|act_w);

	// mask and polarity registers, irq output stage
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			mask_q <= PDIO_MASK_RST;
			pol_q <= PDIO_POL_RST;
			irq_status_o <= PDIO_MASK_RST;
			irq_o <= 1'b0;
		end else if (clk_en_i) begin
			mask_q <= irq_mask_i;
			pol_q <= irq_invert_i;
			irq_status_o <= src_w;
			irq_o <= irq_d;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// a frozen clock enable holds every flop outside reset, so each check except the two reset checks waits for it
	int_disabled_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i && !en_w |=> (&bidir_pin_oe_n_o)) else $error("bidir driven while disabled");
	grp_reset_a: assert property (@(posedge sys_clk_i)
		srst_i |=> (dir_q == PDIO_DIR_RST) && !en_w) else $error("reset state wrong");
	dout_reset_a: assert property (@(posedge sys_clk_i)
		srst_i |=> (dout_q == PDIO_DOUT_RST)) else $error("dout latch not cleared");
	din_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i && !en_w |=> din_rdata_o == PDIO_WORD_ZERO) else $error("din not gated");
	dout_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i && !io_enable_i |=> out_line_oe_n_o) else $error("dout driven while off");
	irq_level_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i |=> irq_o == $past(irq_d)) else $error("irq level mismatch");
	irq_mask_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i && mask_q == PDIO_MASK_RST |=> !irq_o) else $error("masked irq fired");
	rd_in_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i && en_w && !dir_q[0]
		|=> grp_rdata_o[PDIO_GRP_W-1:0] == $past(bidir_pin_i[PDIO_GRP_W-1:0]))
		else $error("input readback wrong");
	rd_out_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i && en_w && dir_q[1]
		|=> grp_rdata_o[PDIO_GRP_W +: PDIO_GRP_W] == $past(latch_q[PDIO_GRP_W +: PDIO_GRP_W]))
		else $error("output readback wrong");

	// refused traffic: direction stays put and irq stays low while disabled
	dir_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i && !en_w |=> $stable(dir_q))
		else $error("direction moved while disabled");
	irq_off_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i && !en_w |=> !irq_o)
		else $error("irq raised while disabled");
	// pin drive shows the latch when no write is in flight
	drive_latch_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i && en_w && dir_q[0] && !grp_wr_i[0]
		|=> bidir_pin_o[PDIO_GRP_W-1:0] == $past(latch_q[PDIO_GRP_W-1:0]))
		else $error("pin drive differs from latch");
	// status shows raw source levels, before polarity and mask
	irq_src_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i |=> irq_status_o == $past(src_w))
		else $error("irq status not raw level");
	// an unmasked source at its active level raises the request
	irq_one_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i && en_w && mask_q[0] && (src_w[0] != pol_q[0]) |=> irq_o)
		else $error("active source did not raise irq");
	// dedicated output word: new data on write, latch otherwise
	dout_wr_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i && en_w && dout_wr_i |=> out_line_o == $past(dout_wdata_i))
		else $error("dout write not driven");
	dout_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		clk_en_i && !(en_w && dout_wr_i) |=> out_line_o == $past(dout_q))
		else $error("dout latch not driven");
endmodule // pdio_top

// ---- rtl/pdio_pkg.sv ----
// package: constants for the digital i/o port block
package pdio_pkg;
	localparam int PDIO_GRP_W = 8;
	localparam int PDIO_NUM_GRP = 3;
	localparam int PDIO_BIDIR_W = 24;
	localparam int PDIO_DED_W = 16;
	localparam int PDIO_IRQ_N = 4;
	localparam int PDIO_IRQ_GRP = 2;
	localparam logic [PDIO_DED_W-1:0] PDIO_DOUT_RST = 16'h0000;
	localparam logic [PDIO_IRQ_N-1:0] PDIO_MASK_RST = 4'h0;
	localparam logic [PDIO_IRQ_N-1:0] PDIO_POL_RST = 4'h0;
	localparam logic [PDIO_NUM_GRP-1:0] PDIO_DIR_RST = 3'h0;
	localparam logic [PDIO_GRP_W-1:0] PDIO_BYTE_ZERO = 8'h00;
	localparam logic [PDIO_DED_W-1:0] PDIO_WORD_ZERO = 16'h0000;
	// enable mode tracking, gray coded
	typedef enum logic [1:0] {
		PDIO_OFF = 2'b00,
		PDIO_ON = 2'b01
	} pdio_mode_t;
endpackage

// ---- test/pdio_field.sv ----
// field side model: resolves each bidir pin from card drive and field level
`timescale 1ns/100ps
module pdio_field (
	// card side
	input wire logic [23:0] pin_o_i,
	input wire logic [23:0] oe_n_i,
	// field side
	input wire logic [23:0] ext_i,
	output logic [23:0] pin_i_o
);
	// field levels are held between settles, long enough to be seen
	assign pin_i_o = (pin_o_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule // pdio_field

// ---- test/tb_top.sv ----
// bench top: random port traffic compared with a reference model
`timescale 1ns/100ps
module tb_top;
	import pdio_pkg::*;
	logic sys_clk_i = 0, srst_i = 1, en = 0, dw = 0, irq, doen, ce = 1;
	logic [3:0] seen = 4'h0;
	logic [2:0] dir = 0, gw = 0;
	logic [7:0] wd = 0;
	logic [3:0] msk = 0, inv = 0, st;
	logic [15:0] dwd = 0, inl = 0, din, dout_o, m_dout = 0;
	logic [23:0] ext = 0, rd, po, oen, pins, m_lat;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	pdio_top pdio_top_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .clk_en_i(ce),
		.io_enable_i(en), .grp_dir_out_i(dir), .grp_wr_i(gw), .grp_wdata_i(wd),
		.dout_wr_i(dw), .dout_wdata_i(dwd), .irq_mask_i(msk), .irq_invert_i(inv),
		.grp_rdata_o(rd), .din_rdata_o(din), .irq_status_o(st), .irq_o(irq),
		.bidir_pin_i(pins), .bidir_pin_o(po), .bidir_pin_oe_n_o(oen),
		.in_line_i(inl), .out_line_o(dout_o), .out_line_oe_n_o(doen));
	pdio_field pdio_field_inst (.pin_o_i(po), .oe_n_i(oen), .ext_i(ext), .pin_i_o(pins));
	// clock and hang guard
	initial forever #50 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task chk(input logic [23:0] g, input logic [23:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task settle;
		repeat (5) @(negedge sys_clk_i);
	endtask
	// expected port state from the reference model
	task check_all;
		logic [23:0] dm, mp;
		dm = {{8{dir[2]}}, {8{dir[1]}}, {8{dir[0]}}} & {24{en}};
		mp = (m_lat & dm) | (ext & ~dm);
		chk(oen, ~dm);
		chk(po & dm, m_lat & dm);
		chk(rd, en ? mp : 24'h0);
		chk(24'(din), 24'(en ? inl : 16'h0));
		chk(24'(doen), 24'(!en));
		chk(24'(dout_o & {16{en}}), 24'(m_dout & {16{en}}));
		chk(24'(st), 24'(mp[19:16]));
		chk(24'(irq), 24'(en & |(msk & (mp[19:16] ^ inv))));
	endtask
	// clock enable low: all outputs hold while enable, field levels, input word, polarity and write strobes move
	task freeze;
		logic [109:0] snap;
		snap = {rd, po, oen, din, dout_o, st, irq, doen};
		ce = 0;
		en = !en;
		ext = ~ext;
		inl = ~inl;
		inv = ~inv;
		gw = 3'h7;
		dw = 1'b1;
		settle();
		comparisons++;
		if ({rd, po, oen, din, dout_o, st, irq, doen} !== snap) begin
			error_cnt++;
			$display("[FAIL] %0t outputs moved while clock enable low", $time);
		end
		ce = 1;
		en = !en;
		ext = ~ext;
		inl = ~inl;
		inv = ~inv;
		gw = 3'h0;
		dw = 1'b0;
		settle();
	endtask
	// host service: read status, flip polarity of changed sources, store status
	task service(input logic [3:0] lvl);
		logic [3:0] fresh;
		ext[19:16] = lvl;
		settle();
		chk(24'(irq), 24'(|(lvl ^ seen)));
		fresh = st;
		inv = inv ^ fresh ^ seen;
		seen = fresh;
		settle();
		chk(24'(irq), 24'h00_0000);
		check_all();
	endtask
	// one-cycle write pulse; ignored by the model while disabled
	task wr(input logic [2:0] g, input logic d);
		gw = g;
		dw = d;
		wd = 8'($urandom);
		dwd = 16'($urandom);
		if (en) begin
			for (int k = 0; k < 3; k++) if (g[k]) m_lat[8*k +: 8] = wd;
			if (d) m_dout = dwd;
		end
		@(negedge sys_clk_i);
		gw = 0;
		dw = 0;
		settle();
	endtask
	task report_and_stop;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// main sequence
	initial begin
		void'($urandom(32'h2444));
		settle();
		srst_i = 0;
		settle();
		check_all();
		en = 1;
		settle();
		check_all();
		wr(3'h7, 1'b0);
		for (int i = 0; i < 60; i++) begin
			en = ($urandom % 5) != 0;
			dir = 3'($urandom);
			ext = 24'($urandom);
			inl = 16'($urandom);
			msk = 4'($urandom);
			inv = 4'($urandom);
			settle();
			wr(3'($urandom), 1'($urandom));
			check_all();
			if (i == 45) freeze();
			if (i == 30) begin
				srst_i = 1;
				en = 0;
				@(negedge sys_clk_i);
				srst_i = 0;
				m_dout = 0;
				settle();
				check_all();
			end
		end
		// irq service flow: group two input, all sources unmasked, no inversion
		en = 1;
		dir = 3'h3;
		msk = 4'hf;
		inv = 4'h0;
		ext = 24'h00_0000;
		settle();
		service(4'($urandom) | 4'h1);
		service(4'h0);
		service(4'h5);
		report_and_stop();
	end
endmodule // tb_top
